// >>> core/scb_sio.sv
// Clock-synchronous 8-bit serial block: clock select, mode and data buffer.
// Assumes a single system clock and a register port with one-cycle strobes.
//
// Behaviour
// RULE_01 - The clock select code 000..110 gives fsys divided by 2^n with n = 3..9, and 111 picks the external clock.
// RULE_02 - After reset and before a mode is chosen the lowest clock select bit reads as one.
// RULE_03 - Once the serial mode is chosen the lowest clock select bit reads its stored value, zero after reset.
// RULE_04 - Software clears the start bit and sets the inhibit bit before changing mode or clock select.
// RULE_05 - Reading the data buffer gives the last received byte, writing it loads the next byte to send.
// RULE_06 - The mode field selects port mode 00, serial mode 01, bus mode 10, with 11 reserved.
// RULE_07 - Data buffer bits 31..8 read zero and both byte fields clear on reset.

`timescale 1ns/1ps
`default_nettype none

module scb_sio
  import scb_pkg::*;
(
  input  wire logic        clk_in,        // System clock, 25 MHz.
  input  wire logic        rst_in,        // Synchronous reset, active high.
  input  wire logic        ce_in,         // Clock enable, freezes state when low.
  input  wire logic [7:0]  addr_in,       // Register byte address.
  input  wire logic [31:0] wdata_in,      // Register write data.
  input  wire logic        wr_in,         // Write strobe.
  input  wire logic        rd_in,         // Read strobe.
  output logic      [31:0] rdata_out,     // Read data, cycle after strobe.
  input  wire logic        sck_in,        // Shift clock pin, input side.
  output logic             sck_out,       // Shift clock pin, output side.
  output logic             sck_oe_n_out,  // Shift clock drive, low drives.
  input  wire logic        si_in,         // Serial data input pin.
  output logic             so_out         // Serial data output pin.
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  scb_shift_if sh ();

  logic                 start_q;
  logic                 inhibit_q;
  logic [2:0]           sck_sel;
  scb_mode_t            mode_q;
  logic                 sio_chosen;
  logic [7:0]           tx_q;
  logic [31:0]          rdata_q;
  logic [SCB_DIV_W-1:0] div_cnt;
  logic                 sck_q;
  logic                 sck_oe_n_q;
  logic                 sck_s1;
  logic                 sck_s2;
  logic                 sck_s3;
  logic                 si_s1;
  logic                 si_s2;
  logic                 ext_clk;
  logic                 tick;
  logic                 wr_ctrl;
  logic                 wr_mode;
  logic                 wr_data;
  logic                 next_start;
  logic                 next_inhibit;
  logic [2:0]           sck_rd;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------

  // Half period in system clocks for a divide by 2^n, n = code + 3.
  function automatic logic [SCB_DIV_W-1:0] half_count(input logic [2:0] code);
    logic [3:0] n;
    n = 4'(code) + 4'(SCB_N_BASE);
    half_count = SCB_DIV_W'(1) << (n - 4'h1);
  endfunction : half_count

  // Write strobe decode for one register offset.
  function automatic logic hit(input logic strobe, input logic [7:0] addr, input logic [7:0] off);
    hit = strobe && (addr == off);
  endfunction : hit

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------

  // Each write hits at most one register; unmapped writes do nothing.
  assign wr_ctrl = hit(wr_in, addr_in, SCB_ADDR_CTRL);
  assign wr_mode = hit(wr_in, addr_in, SCB_ADDR_MODE);
  assign wr_data = hit(wr_in, addr_in, SCB_ADDR_DATA);

  assign next_start   = wdata_in[SCB_CTRL_START_BIT];
  assign next_inhibit = wdata_in[SCB_CTRL_INH_BIT];

  // The external code bypasses the divider. [RULE_01]
  assign ext_clk = (sck_sel == SCB_SCK_EXT);

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------

  // Clock select is taken as written; the divider is not resynchronised
  // because software stops the transfer before changing it. [RULE_04]
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sck_sel <= SCB_SCK_RST;
    end else if (ce_in && wr_ctrl) begin
      sck_sel <= wdata_in[SCB_CTRL_SCK_LSB +: 3]; // [RULE_01]
    end
  end

  // Inhibit is a plain software level.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      inhibit_q <= 1'b1;
    end else if (ce_in && wr_ctrl) begin
      inhibit_q <= next_inhibit;
    end
  end

  // Start reads one while a byte is under way and clears itself at the
  // end. A new write of one in the same cycle as the end wins.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      start_q <= 1'b0;
    end else if (ce_in) begin
      if (wr_ctrl) begin
        start_q <= next_start && !next_inhibit;
      end else if (sh.done || sh.stop) begin
        start_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Mode register
  // ---------------------------------------------------------------

  // Mode codes follow the enumeration; 11 is stored but acts as port mode.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_q <= SCB_MODE_PORT;
    end else if (ce_in && wr_mode) begin
      mode_q <= scb_mode_t'(wdata_in[SCB_MODE_LSB +: 2]); // [RULE_06]
    end
  end

  // Sticky once serial mode has been chosen; only reset clears it.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sio_chosen <= 1'b0;
    end else if (ce_in && wr_mode && (wdata_in[SCB_MODE_LSB +: 2] == SCB_MODE_SIO)) begin
      sio_chosen <= 1'b1; // [RULE_03]
    end
  end

  // ---------------------------------------------------------------
  // Data buffer
  // ---------------------------------------------------------------

  // Transmit byte; reading never returns it, so it only feeds the engine.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tx_q <= SCB_BYTE_RST; // [RULE_07]
    end else if (ce_in && wr_data) begin
      tx_q <= wdata_in[7:0]; // [RULE_05]
    end
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------

  // Two stages on each pin; the third clock stage only serves edge detect.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sck_s1 <= 1'b1;
      sck_s2 <= 1'b1;
      sck_s3 <= 1'b1;
      si_s1  <= 1'b1;
      si_s2  <= 1'b1;
    end else if (ce_in) begin
      sck_s1 <= sck_in;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      si_s1  <= si_in;
      si_s2  <= si_s1;
    end
  end

  // ---------------------------------------------------------------
  // Internal shift clock
  // ---------------------------------------------------------------

  // Divider runs only while a byte is under way, so the clock idles high
  // and every byte starts with a full half period.
  assign tick = sh.busy && !ext_clk && (div_cnt == half_count(sck_sel) - SCB_DIV_W'(1));

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      div_cnt <= '0;
    end else if (ce_in) begin
      if (!sh.busy || ext_clk || tick) begin
        div_cnt <= '0;
      end else begin
        div_cnt <= div_cnt + SCB_DIV_W'(1); // [RULE_01]
      end
    end
  end

  // Shift clock level, toggled at each half period.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sck_q <= 1'b1;
    end else if (ce_in) begin
      if (!sh.busy) begin
        sck_q <= 1'b1;
      end else if (tick) begin
        sck_q <= !sck_q;
      end
    end
  end

  // The pin is driven only in serial mode with an internal clock.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sck_oe_n_q <= 1'b1;
    end else if (ce_in) begin
      sck_oe_n_q <= !((mode_q == SCB_MODE_SIO) && !ext_clk); // [RULE_06]
    end
  end

  // ---------------------------------------------------------------
  // Engine connection
  // ---------------------------------------------------------------

  // Edge events come from the divider or from the synchronised pin.
  assign sh.fall    = ext_clk ? (sck_s3 && !sck_s2) : (tick && sck_q);
  assign sh.rise    = ext_clk ? (!sck_s3 && sck_s2) : (tick && !sck_q);
  assign sh.si      = si_s2;
  assign sh.tx_byte = tx_q;

  // A transfer begins only in serial mode and with inhibit clear.
  // A control write acts on the engine in its own cycle, so one write can
  // clear inhibit and start a byte; the stale inhibit would block it.
  assign sh.start = wr_ctrl && next_start && !next_inhibit && (mode_q == SCB_MODE_SIO) && !sh.busy;
  assign sh.stop  = (wr_ctrl ? next_inhibit : inhibit_q) || (mode_q != SCB_MODE_SIO);

  scb_shifter u_shifter (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .ce_in  (ce_in),
    .sh     (sh.eng)
  );

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------

  // Lowest select bit reads one until serial mode has been chosen.
  always_comb begin
    sck_rd    = sck_sel;
    sck_rd[0] = sio_chosen ? sck_sel[0] : 1'b1; // [RULE_02] [RULE_03]
  end

  // Read data is registered and stands for the one cycle after the strobe.
  // Unmapped addresses read zero.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_q <= SCB_READ_ZERO;
    end else if (ce_in) begin
      rdata_q <= SCB_READ_ZERO;
      if (rd_in) begin
        case (addr_in)
          SCB_ADDR_CTRL: begin
            rdata_q[SCB_CTRL_START_BIT]     <= start_q;
            rdata_q[SCB_CTRL_INH_BIT]       <= inhibit_q;
            rdata_q[SCB_CTRL_SCK_LSB +: 3]  <= sck_rd;
          end
          SCB_ADDR_MODE: begin
            rdata_q                         <= SCB_MODE_FILL;
            rdata_q[SCB_MODE_LSB +: 2]      <= mode_q;
          end
          SCB_ADDR_DATA: begin
            rdata_q[7:0]                    <= sh.rx_byte; // [RULE_05] [RULE_07]
          end
          SCB_ADDR_STAT: begin
            rdata_q                         <= SCB_STAT_FILL;
            rdata_q[SCB_STAT_XFER_BIT]      <= sh.busy;
            rdata_q[SCB_STAT_SHIFT_BIT]     <= sh.busy;
          end
          default: rdata_q <= SCB_READ_ZERO;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  // All pin and bus outputs come straight from flip-flops.
  assign rdata_out    = rdata_q;
  assign sck_out      = sck_q;
  assign sck_oe_n_out = sck_oe_n_q;
  assign so_out       = sh.so;

endmodule : scb_sio

`default_nettype wire

// >>> core/scb_pkg.sv
// Package for the serial clock select and data buffer block.
// Holds register offsets, field positions, reset values and enumerations.
// Assumes every module that uses it imports the whole package.

package scb_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] SCB_ADDR_CTRL = 8'h00;
  localparam logic [7:0] SCB_ADDR_MODE = 8'h04;
  localparam logic [7:0] SCB_ADDR_DATA = 8'h08;
  localparam logic [7:0] SCB_ADDR_STAT = 8'h0C;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SCB_CTRL_START_BIT = 7;
  localparam int SCB_CTRL_INH_BIT   = 5;
  localparam int SCB_CTRL_SCK_LSB   = 0;
  localparam int SCB_MODE_LSB       = 2;
  localparam int SCB_STAT_XFER_BIT  = 3;
  localparam int SCB_STAT_SHIFT_BIT = 2;

  // ---------------------------------------------------------------
  // Reset and fixed read values
  // ---------------------------------------------------------------
  localparam logic [2:0]  SCB_SCK_RST    = 3'h0;
  localparam logic [7:0]  SCB_BYTE_RST   = 8'h00;
  localparam logic [31:0] SCB_MODE_FILL  = 32'h0000_00F3;
  localparam logic [31:0] SCB_STAT_FILL  = 32'h0000_00F3;
  localparam logic [31:0] SCB_READ_ZERO  = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Clock select and transfer counts
  // ---------------------------------------------------------------
  localparam logic [2:0] SCB_SCK_EXT   = 3'h7;
  localparam int         SCB_N_BASE    = 3;
  localparam int         SCB_DIV_W     = 9;
  localparam logic [2:0] SCB_LAST_BIT  = 3'h7;

  typedef enum logic [1:0] {
    SCB_MODE_PORT,
    SCB_MODE_SIO,
    SCB_MODE_I2C,
    SCB_MODE_RSVD
  } scb_mode_t;

  typedef enum logic {
    SCB_ST_IDLE,
    SCB_ST_SHIFT
  } scb_state_t;

endpackage : scb_pkg

// >>> core/scb_shift_if.sv
// Interface between the register and clock logic and the shift engine.
// Assumes both ends run on the same clock.

`timescale 1ns/1ps
`default_nettype none

interface scb_shift_if;
  logic       start;    // One-cycle request to begin a byte.
  logic       stop;     // Level that aborts or forbids a transfer.
  logic       fall;     // Shift clock falling edge event.
  logic       rise;     // Shift clock rising edge event.
  logic       si;       // Synchronised serial input.
  logic [7:0] tx_byte;  // Byte to be sent.
  logic       busy;     // Engine is shifting.
  logic       done;     // One-cycle pulse at end of byte.
  logic       so;       // Serial output bit.
  logic [7:0] rx_byte;  // Last byte received.

  modport ctl (output start, stop, fall, rise, si, tx_byte,
               input  busy, done, so, rx_byte);
  modport eng (input  start, stop, fall, rise, si, tx_byte,
               output busy, done, so, rx_byte);
endinterface : scb_shift_if

`default_nettype wire

// >>> core/scb_shifter.sv
// Eight-bit shift engine, least significant bit first.
// Assumes clock edge events arrive as one-cycle pulses from the caller.

`timescale 1ns/1ps
`default_nettype none

module scb_shifter
  import scb_pkg::*;
(
  input  wire logic clk_in,  // System clock.
  input  wire logic rst_in,  // Synchronous reset, active high.
  input  wire logic ce_in,   // Clock enable.
  scb_shift_if.eng  sh       // Link to the control logic.
);

  scb_state_t state;
  logic [7:0] shreg;
  logic [2:0] bit_cnt;
  logic       so_q;
  logic [7:0] rx_q;
  logic       done_q;
  logic       last_rise;

  // A byte ends on the rising edge that samples its eighth bit.
  assign last_rise = (state == SCB_ST_SHIFT) && sh.rise && (bit_cnt == SCB_LAST_BIT);
  assign sh.busy    = (state == SCB_ST_SHIFT);
  assign sh.so      = so_q;
  assign sh.rx_byte = rx_q;
  assign sh.done    = done_q;

  // Transfer state; a stop request drops back to idle at once.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= SCB_ST_IDLE;
    end else if (ce_in) begin
      case (state)
        SCB_ST_IDLE: begin
          if (sh.start && !sh.stop) begin
            state <= SCB_ST_SHIFT;
          end
        end
        SCB_ST_SHIFT: begin
          if (sh.stop || last_rise) begin
            state <= SCB_ST_IDLE;
          end
        end
        default: state <= SCB_ST_IDLE;
      endcase
    end
  end

  // Shift register and bit counter; data in on rising edges.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shreg   <= SCB_BYTE_RST;
      bit_cnt <= 3'h0;
    end else if (ce_in) begin
      if (state == SCB_ST_IDLE && sh.start) begin
        shreg   <= sh.tx_byte;
        bit_cnt <= 3'h0;
      end else if (state == SCB_ST_SHIFT && sh.rise) begin
        shreg   <= {sh.si, shreg[7:1]};
        bit_cnt <= bit_cnt + 3'h1;
      end
    end
  end

  // Output bit changes on falling edges so it is stable at the rise.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      so_q <= 1'b1;
    end else if (ce_in) begin
      if (state == SCB_ST_IDLE && sh.start) begin
        so_q <= sh.tx_byte[0];
      end else if (state == SCB_ST_SHIFT && sh.fall) begin
        so_q <= shreg[0];
      end
    end
  end

  // Received byte is only replaced by a complete byte. [RULE_05]
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rx_q   <= SCB_BYTE_RST;
      done_q <= 1'b0;
    end else if (ce_in) begin
      done_q <= last_rise && !sh.stop;
      if (last_rise && !sh.stop) begin
        rx_q <= {sh.si, shreg[7:1]};
      end
    end
  end

endmodule : scb_shifter

`default_nettype wire

// >>> tb/scb_sio_sva.sv
// Checker for the serial clock select and data buffer block.
// Assumes it is bound to scb_sio and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module scb_sio_sva
  import scb_pkg::*;
(
  input wire logic        clk_in,        // System clock.
  input wire logic        rst_in,        // Synchronous reset.
  input wire logic        ce_in,         // Clock enable.
  input wire logic [7:0]  addr_in,       // Register address.
  input wire logic [31:0] wdata_in,      // Write data.
  input wire logic        wr_in,         // Write strobe.
  input wire logic        rd_in,         // Read strobe.
  input wire logic [31:0] rdata_out,     // Read data.
  input wire logic        sck_in,        // Shift clock in.
  input wire logic        sck_out,       // Shift clock out.
  input wire logic        sck_oe_n_out,  // Shift clock drive.
  input wire logic        si_in,         // Serial in.
  input wire logic        so_out         // Serial out.
);
  logic        sio_seen;
  logic [2:0]  sel_q;
  logic [1:0]  mode_q;
  logic        sck_q;
  logic [11:0] cnt;
  wire         drive_q = (mode_q == 2'h1) && (sel_q != SCB_SCK_EXT);
  wire  [11:0] half = 12'h001 << ({1'b0, sel_q} + 4'h2);
  // ---------------------------------------------------------------
  // Shadow of the software settings.
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) sel_q <= SCB_SCK_RST;
    else if (ce_in && wr_in && addr_in == SCB_ADDR_CTRL) sel_q <= wdata_in[2:0];
  end
  // The serial mode flag stays set once seen, as the low select bit does.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_q   <= 2'h0;
      sio_seen <= 1'b0;
    end else if (ce_in && wr_in && addr_in == SCB_ADDR_MODE) begin
      mode_q   <= wdata_in[3:2];
      sio_seen <= sio_seen | (wdata_in[3:2] == 2'h1);
    end
  end
  // Cycles since the shift clock last changed.
  always_ff @(posedge clk_in) begin
    sck_q <= rst_in ? 1'b1 : sck_out;
    cnt   <= rst_in ? 12'h000 : ((sck_out != sck_q) ? 12'h001 : cnt + 12'h001);
  end
  // ---------------------------------------------------------------
  // Properties.
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_rd(logic [7:0] a);
    rd_in && ce_in && addr_in == a;
  endsequence
  a_rdata_idle: assert property (!rd_in && ce_in |=> rdata_out == SCB_READ_ZERO)
    else $error("read data not zero without a read");
  a_data_upper: assert property (s_rd(SCB_ADDR_DATA) |=> rdata_out[31:8] == 24'h000000)
    else $error("data buffer upper bits not zero");
  a_sel_low_reset: assert property (s_rd(SCB_ADDR_CTRL) ##0 !sio_seen |=> rdata_out[0] == 1'b1)
    else $error("low select bit not one before serial mode");
  a_sel_low_sio: assert property (s_rd(SCB_ADDR_CTRL) ##0 sio_seen |=> rdata_out[0] == sel_q[0])
    else $error("low select bit not stored value in serial mode");
  a_mode_back: assert property (s_rd(SCB_ADDR_MODE) |=> rdata_out[7:0] == {4'hF, mode_q, 2'h3})
    else $error("mode field read back wrong");
  a_reset_idle: assert property ($fell(rst_in) |-> sck_out && sck_oe_n_out && so_out)
    else $error("pins not idle after reset");
  a_half_period: assert property ($rose(sck_out) && !sck_oe_n_out && !$past(wr_in, 1)
    && !$past(wr_in, 2) && !$past(wr_in, 3) |-> cnt == half)
    else $error("shift clock low phase length wrong");
  a_oe_drive: assert property (!$past(rst_in) |-> sck_oe_n_out == !$past(drive_q))
    else $error("shift clock drive does not follow mode and select");
endmodule : scb_sio_sva
bind scb_sio scb_sio_sva chk (.clk_in, .rst_in, .ce_in, .addr_in, .wdata_in, .wr_in, .rd_in,
  .rdata_out, .sck_in, .sck_out, .sck_oe_n_out, .si_in, .so_out);
`default_nettype wire

// >>> tb/scb_peer.sv
// Far-side serial peer: sends and takes one byte LSB first per frame.
// Assumes the bench pulses load_in before each frame and holds byte_in.
`timescale 1ns/1ps
`default_nettype none
module scb_peer (
  input  wire logic       load_in,  // Arms a new frame.
  input  wire logic [7:0] byte_in,  // Byte the peer sends.
  input  wire logic       sck_in,   // Resolved shift clock line.
  input  wire logic       so_in,    // Device serial output.
  output logic            si_out,   // Peer data towards the device.
  output logic      [7:0] rx_out    // Byte the peer received.
);
  int n;
  // Bit 0 is presented at arming; the first falling edge keeps it.
  always @(posedge load_in) begin
    n = 0;
    si_out = byte_in[0];
  end
  // Later bits follow each falling edge after a sample.
  always @(negedge sck_in) if (n > 0 && n < 8) si_out <= byte_in[n];
  // Sample on rising edges; once the hold time is over the line stops holding data.
  always @(posedge sck_in) begin
    rx_out <= {so_in, rx_out[7:1]};
    if (n == 7) si_out <= #200 ~byte_in[7];
    n <= n + 1;
  end
  initial begin
    n = 8;
    si_out = 1'b1;
    rx_out = 8'h00;
  end
endmodule : scb_peer
`default_nettype wire

// >>> tb/scb_sio_tb.sv
// Self-checking bench for the serial clock select and data buffer block.
// Assumes the checker is bound and the peer model sits on the shift pins.
`timescale 1ns/1ps
`default_nettype none
module scb_sio_tb
  import scb_pkg::*;
;
  typedef struct packed {
    logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] mask; logic [31:0] exp;
  } scb_row_t;
  logic        clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
  logic        ext_sck = 1'b1, load = 1'b0, ce_in = 1'b1;
  logic [7:0]  addr_in = 8'h00, peer_byte = 8'h00, peer_rx, last_pb;
  logic [31:0] wdata_in = 32'h0, rdata_out, got;
  logic        sck_out, sck_oe_n_out, so_out, si_line;
  int          n_fail = 0, cmp_count = 0;
  // Whoever has the drive enable owns the shift clock line.
  wire         sck_line = sck_oe_n_out ? ext_sck : sck_out;
  scb_row_t    rows [9] = '{
    '{SCB_ADDR_CTRL, 32'h26, SCB_ADDR_CTRL, 32'hA7, 32'h27}, '{SCB_ADDR_MODE, 32'h00, SCB_ADDR_MODE, 32'hFF, 32'hF3},
    '{SCB_ADDR_MODE, 32'h08, SCB_ADDR_MODE, 32'hFF, 32'hFB}, '{SCB_ADDR_MODE, 32'h0C, SCB_ADDR_MODE, 32'hFF, 32'hFF},
    '{SCB_ADDR_DATA, 32'hFFFF_FFA5, SCB_ADDR_DATA, 32'hFFFF_FFFF, 32'h0}, '{8'h10, 32'hFFFF_FFFF, 8'h10, 32'hFFFF_FFFF, 32'h0},
    '{SCB_ADDR_MODE, 32'h04, SCB_ADDR_MODE, 32'hFF, 32'hF7}, '{SCB_ADDR_CTRL, 32'h20, SCB_ADDR_CTRL, 32'hA7, 32'h20},
    '{8'h14, 32'hFF, SCB_ADDR_STAT, 32'hFF, 32'hF3}};
  always #20 clk_in = ~clk_in;
  scb_sio uut (.clk_in, .rst_in, .ce_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .sck_in(sck_line), .sck_out, .sck_oe_n_out, .si_in(si_line), .so_out);
  scb_peer peer (.load_in(load), .byte_in(peer_byte), .sck_in(sck_line), .so_in(so_out),
    .si_out(si_line), .rx_out(peer_rx));
  // ---------------------------------------------------------------
  // Bus tasks: one-cycle strobes, read data taken in the following cycle.
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 got = rdata_out;
  endtask : rd
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(name, e, got & m);
  endtask : rchk
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic do_reset;
    rst_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
  endtask : do_reset
  // Polls the busy flag; a bounded count ends the wait on a stuck transfer.
  task automatic wait_idle;
    for (int i = 0; i < 3000; i++) begin
      rd(SCB_ADDR_STAT);
      if (got[3] === 1'b0) break;
    end
    chk("stat_busy", 32'h0, {31'h0, got[3]});
  endtask : wait_idle
  // Stop and inhibit come first so the select and mode change while idle.
  task automatic xfer(input logic [2:0] sel, input logic [7:0] tx, input logic [7:0] pb);
    wr(SCB_ADDR_CTRL, 32'h20 | sel);
    wr(SCB_ADDR_MODE, 32'h04);
    wr(SCB_ADDR_DATA, {24'h0, tx});
    peer_byte = pb;
    load = 1'b1;
    #1 load = 1'b0;
    wr(SCB_ADDR_CTRL, 32'h80 | sel);
    if (sel == SCB_SCK_EXT) repeat (8) begin
      repeat (4) @(posedge clk_in);
      ext_sck <= 1'b0;
      repeat (4) @(posedge clk_in);
      ext_sck <= 1'b1;
    end
    wait_idle;
    chk("peer_rx", {24'h0, tx}, {24'h0, peer_rx});
    rchk("rx_byte", SCB_ADDR_DATA, 32'hFFFF_FFFF, {24'h0, pb});
  endtask : xfer
  initial begin
    repeat (40000) @(posedge clk_in);
    n_fail++;
    conclude;
  end
  initial begin
    do_reset;
    rchk("ctrl_rst", SCB_ADDR_CTRL, 32'hA7, 32'h21);
    rchk("data_rst", SCB_ADDR_DATA, 32'hFFFF_FFFF, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      rchk($sformatf("row%0d", i), rows[i].ra, rows[i].mask, rows[i].exp);
    end
    // Every select code, the last one clocked from the far side.
    for (int s = 0; s < 8; s++) begin
      last_pb = 8'h96 ^ 8'(s * 17);
      xfer(3'(s), 8'hC3 + 8'(s), last_pb);
    end
    // Inhibit in mid-byte aborts at once and leaves the received byte alone.
    wr(SCB_ADDR_CTRL, 32'h26);
    wr(SCB_ADDR_DATA, 32'h3C);
    wr(SCB_ADDR_CTRL, 32'h86);
    repeat (700) @(posedge clk_in);
    wr(SCB_ADDR_CTRL, 32'h26);
    rchk("abort_stat", SCB_ADDR_STAT, 32'h0C, 32'h0);
    rchk("abort_rx", SCB_ADDR_DATA, 32'hFFFF_FFFF, {24'h0, last_pb});
    wr(SCB_ADDR_CTRL, 32'hA6);
    rchk("inh_stat", SCB_ADDR_STAT, 32'h0C, 32'h0);
    // A write while the clock enable is low must leave the control register alone.
    @(posedge clk_in);
    ce_in <= 1'b0;
    wr(SCB_ADDR_CTRL, 32'h87);
    ce_in <= 1'b1;
    rchk("ce_hold", SCB_ADDR_CTRL, 32'hA7, 32'h26);
    // A second reset in mid-byte brings back the reset values.
    wr(SCB_ADDR_CTRL, 32'h86);
    repeat (50) @(posedge clk_in);
    do_reset;
    rchk("ctrl_rst2", SCB_ADDR_CTRL, 32'hA7, 32'h21);
    rchk("data_rst2", SCB_ADDR_DATA, 32'hFFFF_FFFF, 32'h0);
    rchk("mode_rst2", SCB_ADDR_MODE, 32'hFF, 32'hF3);
    conclude;
  end
endmodule : scb_sio_tb
`default_nettype wire
